// ==== design/floppy_regs_pkg.sv ====
package floppy_regs_pkg;
    localparam logic [9:0] ADDR_TAPE = 10'h3f3;
    localparam logic [9:0] ADDR_STATUS = 10'h3f4;
    localparam logic [9:0] ADDR_DATA = 10'h3f5;

    localparam logic [7:0] RATE_SEL_RESET = 8'h02;
    localparam int SWRST_BIT = 7;
    localparam int LOWPWR_BIT = 6;
    localparam int WRITE_DELAY_CODE_LSB = 2;
    localparam int WRITE_DELAY_CODE_MSB = 4;
    localparam int RATE_LSB = 0;
    localparam int RATE_MSB = 1;
    localparam logic [1:0] TAPE_RESET = 2'h0;

    localparam int ST_RQM = 7;
    localparam int ST_DIR = 6;
    localparam int ST_NONDMA = 5;
    localparam int ST_BUSY = 4;

    localparam logic [7:0] OE_ALL = 8'hff;
    localparam logic [7:0] OE_TAPE_NORMAL = 8'h03;
    localparam logic [7:0] OE_NONE = 8'h00;

    localparam logic [2:0] WRITE_DELAY_CODE_OFF = 3'h7;
    localparam logic [2:0] WRITE_DELAY_CODE_DEF = 3'h0;
    // delays in units of 10 ps
    localparam logic [14:0] DLY_0 = 15'h0000;
    localparam logic [14:0] DLY_1 = 15'h1047;
    localparam logic [14:0] DLY_2 = 15'h208e;
    localparam logic [14:0] DLY_3 = 15'h30d4;
    localparam logic [14:0] DLY_4 = 15'h411b;
    localparam logic [14:0] DLY_5 = 15'h5161;
    localparam logic [14:0] DLY_6 = 15'h61a8;

    localparam logic [1:0] RATE_1M = 2'h3;
    localparam logic [1:0] RATE_500K = 2'h0;
    localparam logic [1:0] RATE_300K = 2'h1;
    localparam logic [1:0] RATE_250K = 2'h2;
    localparam logic [1:0] OPT_STD = 2'h0;
    localparam logic [1:0] OPT_3MODE = 2'h1;
    localparam logic [1:0] OPT_2M = 2'h2;
    localparam logic [11:0] KBPS_2000 = 12'h7d0;
    localparam logic [11:0] KBPS_1000 = 12'h3e8;
    localparam logic [11:0] KBPS_500 = 12'h1f4;
    localparam logic [11:0] KBPS_300 = 12'h12c;
    localparam logic [11:0] KBPS_250 = 12'h0fa;
    localparam logic [11:0] KBPS_NONE = 12'h000;

    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_AW = 4;
    localparam logic [4:0] FIFO_CAP_ON = 5'h10;
    localparam logic [4:0] FIFO_CAP_OFF = 5'h01;
    localparam logic [7:0] PAD_BYTE = 8'h00;
    localparam logic [7:0] TRACK_DEFAULT = 8'h00;

    typedef enum logic [1:0] {PH_IDLE, PH_CMD, PH_EXEC, PH_RESULT} phase_t;

    typedef struct packed {
        logic enhanced_mode_two;
        logic [7:0] drive_type_config;
        logic [1:0] boot_drive_config;
        logic [1:0] last_drive;
        logic drive_rate_option_hi;
        logic drive_rate_option_lo;
        logic density_polarity;
        logic polled_mode;
        logic config_control_wr;
        logic [1:0] config_control_rate;
        logic output_control_reset;
        logic configure_wr;
        logic configure_fifo_en;
        logic [3:0] configure_threshold;
        logic [7:0] configure_track;
    } cfg_in_t;

    typedef struct packed {
        logic [3:0] drive_seek_flag;
        logic go_exec;
        logic go_result;
        logic go_idle;
        logic exec_read;
        logic exec_done;
        logic disk_push;
        logic [7:0] disk_data;
        logic disk_pop;
        logic result_valid;
        logic [7:0] result_data;
        logic result_last;
    } core_in_t;

    typedef struct packed {
        logic cmd_byte_valid;
        logic [7:0] cmd_byte;
        logic [7:0] disk_data;
        logic fifo_empty;
        logic fifo_full;
        logic threshold_hit;
        logic xfer_error;
        logic result_take;
        logic soft_reset;
        logic low_power;
        logic fifo_on;
        logic [3:0] fifo_threshold;
        logic [7:0] write_delay_code_track;
    } core_out_t;
endpackage : floppy_regs_pkg

// ==== design/floppy_regs.sv ====
`timescale 1ns/1ps
// Contract
// - normal mode: tape bits 1:0 only, rest undriven
// - enhanced: bits 5:4 drive type by drive
// - enhanced: bits 3:2 are boot drive bits
// - enhanced: rate pins inputs into bits 7:6
// - rate follows latest rate or config write
// - hard reset loads 02h; soft reset keeps
// - bits 4:2 select precompensation delay
// - code 000 default 41.67 at 1M, else 125
// - precompensation start track, default zero, configurable
// - bit 6 low power; exits on access/reset
// - bit 7 self-clearing software reset
// - rate codes map to speed per option
// - density output high for fast rates, polarity
// - normal mode: rate pins copy rate bits
// - status readable anytime; host reads before bytes
// - status bits 3:0 show drive seeking
// - busy bit from first byte to end
// - bit 5 set in polled execution
// - bit 7 permits access, bit 6 direction
// - data port comes from reset FIFO-disabled
// - FIFO off in command, cleared at execution
// - overrun/underrun ends; write pads; read drains
module floppy_regs
    import floppy_regs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [9:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    output logic [7:0] rdata_oe,
    input wire cfg_in_t cfg,
    input wire core_in_t core_in,
    output core_out_t core_out,
    input wire logic rate_pin_low_in,
    output logic rate_pin_low_out,
    output logic rate_pin_low_oe,
    input wire logic rate_pin_high_in,
    output logic rate_pin_high_out,
    output logic rate_pin_high_oe,
    output logic density_select_out,
    output logic [1:0] rate_code,
    output logic [11:0] mfm_rate_kbps,
    output logic [11:0] fm_rate_kbps,
    output logic [2:0] write_delay_code,
    output logic [14:0] write_delay_code_delay
);
    function automatic logic [11:0] rate_kbps(input logic [1:0] code,
                                              input logic [1:0] opt);
        logic [11:0] r;
        r = KBPS_250;
        if (code == RATE_1M) begin
            r = KBPS_1000;
        end else if (code == RATE_500K) begin
            r = KBPS_500;
        end else if (code == RATE_300K) begin
            if (opt == OPT_3MODE) begin
                r = KBPS_500;
            end else if (opt == OPT_2M) begin
                r = KBPS_2000;
            end else begin
                r = KBPS_300;
            end
        end
        return r;
    endfunction : rate_kbps

    logic [1:0] tape_pick;
    logic [2:0] pin_low_sync;
    logic [2:0] pin_high_sync;
    logic [1:0] pin_level;
    logic low_power;
    logic soft_reset;
    logic fifo_on;
    logic [3:0] fifo_threshold;
    logic [7:0] write_delay_code_track;
    phase_t phase;
    logic exec_end;
    logic xfer_error;
    logic [7:0] fifo_mem [FIFO_DEPTH];
    logic [FIFO_AW-1:0] rd_ptr;
    logic [FIFO_AW-1:0] wr_ptr;
    logic [4:0] fifo_count;
    logic [7:0] cmd_byte;
    logic cmd_byte_valid;
    logic [7:0] next_rdata;
    logic [7:0] next_oe;
    logic [7:0] status;
    logic [7:0] tape_view;
    logic wr_tape, wr_rate, wr_data, rd_status, rd_data;
    logic fifo_empty, fifo_full, host_push, host_pop, core_push, core_pop;
    logic fifo_push, fifo_pop, host_transfer_permit, dir, result_take;
    logic [1:0] rate_opt;

    assign wr_tape = wr && (addr == ADDR_TAPE);
    assign wr_rate = wr && (addr == ADDR_STATUS);
    assign wr_data = wr && (addr == ADDR_DATA);
    assign rd_status = rd && (addr == ADDR_STATUS);
    assign rd_data = rd && (addr == ADDR_DATA);
    assign rate_opt = {cfg.drive_rate_option_hi, cfg.drive_rate_option_lo};

    // tape select bits
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tape_pick <= TAPE_RESET;
        end else if (wr_tape) begin
            tape_pick <= wdata[1:0];
        end
    end

    // rate pins: no reset, so neither reset touches bits 7:6
    always_ff @(posedge clk_sys) begin
        pin_low_sync <= {pin_low_sync[1:0], rate_pin_low_in};
        pin_high_sync <= {pin_high_sync[1:0], rate_pin_high_in};
        if (pin_low_sync[1] == pin_low_sync[2]) begin
            pin_level[0] <= pin_low_sync[2];
        end
        if (pin_high_sync[1] == pin_high_sync[2]) begin
            pin_level[1] <= pin_high_sync[2];
        end
    end

    // rate select fields; soft reset leaves them alone
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rate_code <= RATE_SEL_RESET[RATE_MSB:RATE_LSB];
            write_delay_code <= RATE_SEL_RESET[WRITE_DELAY_CODE_MSB:WRITE_DELAY_CODE_LSB];
        end else if (wr_rate) begin
            rate_code <= wdata[RATE_MSB:RATE_LSB];
            write_delay_code <= wdata[WRITE_DELAY_CODE_MSB:WRITE_DELAY_CODE_LSB];
        end else if (cfg.config_control_wr) begin
            rate_code <= cfg.config_control_rate;
        end
    end

    // self-clearing software reset pulse
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            soft_reset <= 1'b0;
        end else begin
            soft_reset <= (wr_rate && wdata[SWRST_BIT])
                          || cfg.output_control_reset;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            low_power <= 1'b0;
        end else if (wr_rate && wdata[LOWPWR_BIT]) begin
            low_power <= 1'b1;
        end else if (soft_reset || rd_status || rd_data || wr_data) begin
            low_power <= 1'b0;
        end
    end

    // configure command settings
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            fifo_on <= 1'b0;
            fifo_threshold <= '0;
            write_delay_code_track <= TRACK_DEFAULT;
        end else if (soft_reset) begin
            fifo_on <= 1'b0;
            write_delay_code_track <= TRACK_DEFAULT;
        end else if (cfg.configure_wr) begin
            fifo_on <= cfg.configure_fifo_en;
            fifo_threshold <= cfg.configure_threshold;
            write_delay_code_track <= cfg.configure_track;
        end
    end

    // precompensation delay
    always_comb begin
        case (write_delay_code)
            WRITE_DELAY_CODE_OFF: write_delay_code_delay = DLY_0;
            3'h1: write_delay_code_delay = DLY_1;
            3'h2: write_delay_code_delay = DLY_2;
            3'h3: write_delay_code_delay = DLY_3;
            3'h4: write_delay_code_delay = DLY_4;
            3'h5: write_delay_code_delay = DLY_5;
            3'h6: write_delay_code_delay = DLY_6;
            default: write_delay_code_delay = (rate_code == RATE_1M) ? DLY_1 : DLY_3;
        endcase
    end

    assign mfm_rate_kbps = rate_kbps(rate_code, rate_opt);
    assign fm_rate_kbps = (mfm_rate_kbps >= KBPS_1000) ? KBPS_NONE
                          : (mfm_rate_kbps >> 1);
    // fast codes are 11 and 00
    assign density_select_out = ((rate_code == RATE_1M)
        || (rate_code == RATE_500K)) == cfg.density_polarity;
    assign rate_pin_low_out = rate_code[0];
    assign rate_pin_high_out = rate_code[1];
    assign rate_pin_low_oe = !cfg.enhanced_mode_two;
    assign rate_pin_high_oe = !cfg.enhanced_mode_two;

    // command phase tracking
    assign host_transfer_permit = (phase == PH_EXEC)
                 ? (core_in.exec_read ? !fifo_empty : !fifo_full)
                 : (phase == PH_RESULT) ? core_in.result_valid : 1'b1;
    assign dir = (phase == PH_RESULT)
                 || ((phase == PH_EXEC) && core_in.exec_read);
    assign result_take = rd_data && (phase == PH_RESULT)
                         && core_in.result_valid;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            phase <= PH_IDLE;
        end else if (soft_reset) begin
            phase <= PH_IDLE;
        end else begin
            case (phase)
                PH_IDLE: begin
                    if (wr_data) begin
                        phase <= PH_CMD;
                    end
                end
                PH_CMD: begin
                    if (core_in.go_exec) begin
                        phase <= PH_EXEC;
                    end else if (core_in.go_result) begin
                        phase <= PH_RESULT;
                    end else if (core_in.go_idle) begin
                        phase <= PH_IDLE;
                    end
                end
                PH_EXEC: begin
                    if (exec_end && (!core_in.exec_read || fifo_empty)) begin
                        phase <= PH_RESULT;
                    end
                end
                default: begin
                    if (result_take && core_in.result_last) begin
                        phase <= PH_IDLE;
                    end
                end
            endcase
        end
    end

    // end of execution, by completion or by overrun/underrun
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            exec_end <= 1'b0;
            xfer_error <= 1'b0;
        end else begin
            xfer_error <= (phase == PH_EXEC) && !exec_end
                          && ((core_push && fifo_full)
                              || (core_pop && fifo_empty));
            if (phase != PH_EXEC) begin
                exec_end <= 1'b0;
            end else if (core_in.exec_done || xfer_error) begin
                exec_end <= 1'b1;
            end
        end
    end

    // data FIFO; one byte deep unless enabled by configure
    assign fifo_empty = (fifo_count == '0);
    assign fifo_full = fifo_count >= (fifo_on ? FIFO_CAP_ON : FIFO_CAP_OFF);
    assign host_push = wr_data && (phase == PH_EXEC) && !core_in.exec_read
                       && !exec_end;
    assign host_pop = rd_data && (phase == PH_EXEC) && core_in.exec_read;
    assign core_push = core_in.disk_push && core_in.exec_read;
    assign core_pop = core_in.disk_pop && !core_in.exec_read;
    assign fifo_push = (phase == PH_EXEC) && !exec_end && !fifo_full
                       && (host_push || core_push);
    assign fifo_pop = (phase == PH_EXEC) && !fifo_empty
                      && (host_pop || core_pop);

    always_ff @(posedge clk_sys) begin
        if (fifo_push) begin
            fifo_mem[wr_ptr] <= host_push ? wdata : core_in.disk_data;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rd_ptr <= '0;
            wr_ptr <= '0;
            fifo_count <= '0;
        end else if (soft_reset || (phase != PH_EXEC)) begin
            rd_ptr <= '0;
            wr_ptr <= '0;
            fifo_count <= '0;
        end else begin
            if (fifo_push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (fifo_pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            fifo_count <= fifo_count + {4'h0, fifo_push}
                          - {4'h0, fifo_pop};
        end
    end

    // command bytes pass straight to the sequencer
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cmd_byte_valid <= 1'b0;
            cmd_byte <= '0;
        end else begin
            cmd_byte_valid <= wr_data && ((phase == PH_IDLE)
                                          || (phase == PH_CMD));
            if (wr_data) begin
                cmd_byte <= wdata;
            end
        end
    end

    assign core_out.cmd_byte_valid = cmd_byte_valid;
    assign core_out.cmd_byte = cmd_byte;
    assign core_out.disk_data = fifo_empty ? PAD_BYTE
                                : fifo_mem[rd_ptr];
    assign core_out.fifo_empty = fifo_empty;
    assign core_out.fifo_full = fifo_full;
    assign core_out.threshold_hit = fifo_on
                                    && (fifo_count >= {1'b0, fifo_threshold});
    assign core_out.xfer_error = xfer_error;
    assign core_out.result_take = result_take;
    assign core_out.soft_reset = soft_reset;
    assign core_out.low_power = low_power;
    assign core_out.fifo_on = fifo_on;
    assign core_out.fifo_threshold = fifo_threshold;
    assign core_out.write_delay_code_track = write_delay_code_track;

    // register read path
    always_comb begin
        status = {4'h0, core_in.drive_seek_flag};
        status[ST_RQM] = host_transfer_permit;
        status[ST_DIR] = dir;
        status[ST_NONDMA] = cfg.polled_mode && (phase == PH_EXEC);
        status[ST_BUSY] = (phase != PH_IDLE);
        tape_view = {6'h00, tape_pick};
        if (cfg.enhanced_mode_two) begin
            tape_view[7:6] = {pin_level[1], pin_level[0]};
            tape_view[5:4] = cfg.drive_type_config[
                {cfg.last_drive, 1'b0} +: 2];
            tape_view[3:2] = cfg.boot_drive_config;
        end
        next_rdata = '0;
        next_oe = OE_NONE;
        if (rd && (addr == ADDR_TAPE)) begin
            next_rdata = tape_view;
            next_oe = cfg.enhanced_mode_two ? OE_ALL : OE_TAPE_NORMAL;
        end else if (rd_status) begin
            next_rdata = status;
            next_oe = OE_ALL;
        end else if (rd_data) begin
            next_oe = OE_ALL;
            if (phase == PH_RESULT) begin
                next_rdata = core_in.result_data;
            end else if (host_pop && !fifo_empty) begin
                next_rdata = fifo_mem[rd_ptr];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rdata <= '0;
            rdata_oe <= OE_NONE;
        end else begin
            rdata <= next_rdata & next_oe;
            rdata_oe <= next_oe;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    a_tape_normal_oe: assert property (
        rd && addr == ADDR_TAPE && !cfg.enhanced_mode_two
        |=> rdata_oe == OE_TAPE_NORMAL && rdata[7:2] == 6'h00)
        else $error("tape read drives high bits in normal mode");
    a_drive_type_sel: assert property (
        rd && addr == ADDR_TAPE && cfg.enhanced_mode_two
        && cfg.last_drive == 2'h3 && $stable(cfg.drive_type_config)
        |=> rdata[5:4] == cfg.drive_type_config[7:6])
        else $error("drive type bits wrong for drive 3");
    a_boot_drive_bits: assert property (
        rd && addr == ADDR_TAPE && cfg.enhanced_mode_two
        |=> rdata[3:2] == $past(cfg.boot_drive_config))
        else $error("boot drive bits wrong");
    a_rate_follow: assert property (
        wr_rate ##1 !wr_rate && !cfg.config_control_wr
        |-> rate_code == $past(wdata[RATE_MSB:RATE_LSB])
        ##1 $stable(rate_code))
        else $error("rate select write not held");
    a_rate_soft_keep: assert property (
        soft_reset && !wr_rate && !cfg.config_control_wr
        |=> $stable(rate_code) && $stable(write_delay_code))
        else $error("soft reset changed rate select");
    a_write_delay_code_default: assert property (
        write_delay_code == WRITE_DELAY_CODE_DEF && rate_code != RATE_1M
        |-> write_delay_code_delay == DLY_3)
        else $error("default delay not 125 ns");
    a_low_power_exit: assert property (
        low_power && (rd_status || rd_data) ##1 !wr_rate
        |-> !low_power)
        else $error("low power not left on access");
    a_swrst_pulse: assert property (
        wr_rate && wdata[SWRST_BIT] ##1 !wr_rate && !cfg.output_control_reset
        |-> soft_reset ##1 !soft_reset)
        else $error("software reset not one cycle");
    a_density_fast: assert property (
        rate_code == RATE_500K |-> density_select_out == cfg.density_polarity)
        else $error("density output wrong for 500k");
    a_pins_copy: assert property (
        !cfg.enhanced_mode_two |-> rate_pin_low_oe && rate_pin_high_oe
        && {rate_pin_high_out, rate_pin_low_out} == rate_code)
        else $error("rate pins do not follow rate code");
    a_busy_bit: assert property (
        phase == PH_IDLE && wr_data && !soft_reset
        ##1 !soft_reset && !core_in.go_idle ##1 rd_status
        |=> rdata[ST_BUSY])
        else $error("busy not set after first byte");
    a_exec_fifo_clear: assert property (
        phase != PH_EXEC ##1 phase == PH_EXEC |-> fifo_count == '0)
        else $error("fifo not cleared at execution");
    a_read_drain: assert property (
        phase == PH_EXEC && core_in.exec_read && !fifo_empty
        |=> phase == PH_EXEC)
        else $error("result phase entered before drain");

    c_full_command: cover property (phase == PH_RESULT ##1 phase == PH_IDLE);
    c_fifo_fills: cover property (fifo_on && fifo_full);
    c_overrun: cover property (xfer_error);
    c_enhanced_read: cover property (rd && addr == ADDR_TAPE
                                     && cfg.enhanced_mode_two);
endmodule : floppy_regs

// ==== sim/host_model.sv ====
`timescale 1ns/1ps
module host_model
    import floppy_regs_pkg::*;
(
    input wire logic clk_sys,
    output logic [9:0] addr,
    output logic [7:0] wdata,
    output logic wr,
    output logic rd,
    input wire logic [7:0] rdata,
    input wire logic [7:0] rdata_oe
);
    initial begin
        addr = 10'h000;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end
    task write_reg(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
        #1;
    endtask : write_reg
    task read_reg(input logic [9:0] a, output logic [7:0] d,
        output logic [7:0] oe);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1;
        d = rdata;
        oe = rdata_oe;
    endtask : read_reg
    // poll status before each data byte
    task put_byte(input logic [7:0] d, output logic ok);
        logic [7:0] s;
        logic [7:0] oe;
        ok = 1'b0;
        for (int i = 0; i < 20 && !ok; i++) begin
            read_reg(ADDR_STATUS, s, oe);
            ok = (s[ST_RQM] === 1'b1) && (s[ST_DIR] === 1'b0);
        end
        if (ok) begin
            write_reg(ADDR_DATA, d);
        end
    endtask : put_byte
endmodule : host_model

// ==== sim/floppy_regs_test.sv ====
`timescale 1ns/1ps
module floppy_regs_test;
    import floppy_regs_pkg::*;
    logic clk_sys, resetn, wr, rd, ok, lo_out, lo_oe, hi_in, lo_in, hi_out;
    logic hi_oe, dens;
    logic [9:0] addr;
    logic [7:0] wdata, rdata, rdata_oe, d, oe;
    logic [1:0] rc;
    logic [2:0] wdc;
    logic [11:0] mfm, fm;
    logic [14:0] pd;
    cfg_in_t cfg;
    core_in_t core_in;
    core_out_t core_out;
    int failures = 0;
    int checked = 0;
    int cycles = 0;
    logic [11:0] mfm_t[4] = '{KBPS_500, KBPS_300, KBPS_250, KBPS_1000};
    logic [11:0] fm_t[4] = '{12'h0fa, 12'h096, 12'h07d, KBPS_NONE};
    logic [14:0] dly_t[8] = '{DLY_3, DLY_1, DLY_2, DLY_3, DLY_4, DLY_5,
        DLY_6, DLY_0};
    floppy_regs u_floppy_regs (.clk_sys(clk_sys), .resetn(resetn),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .rdata_oe(rdata_oe), .cfg(cfg), .core_in(core_in),
        .core_out(core_out), .rate_pin_low_in(lo_in),
        .rate_pin_low_out(lo_out), .rate_pin_low_oe(lo_oe),
        .rate_pin_high_in(hi_in), .rate_pin_high_out(hi_out),
        .rate_pin_high_oe(hi_oe), .density_select_out(dens),
        .rate_code(rc), .mfm_rate_kbps(mfm), .fm_rate_kbps(fm),
        .write_delay_code(wdc), .write_delay_code_delay(pd));
    host_model u_host_model (.clk_sys(clk_sys), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .rdata_oe(rdata_oe));
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            end_sim();
        end
    end
    task chk(input logic [14:0] got, input logic [14:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task end_sim;
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim
    task t_reset;
        chk(rc, RATE_250K);
        chk(pd, DLY_3);
        u_host_model.read_reg(ADDR_TAPE, d, oe);
        chk(oe, OE_TAPE_NORMAL);
        u_host_model.read_reg(ADDR_STATUS, d, oe);
        chk(d, 8'h80);
        $display("reset done");
    endtask : t_reset
    task t_rates;
        for (int c = 0; c < 4; c++) begin
            u_host_model.write_reg(ADDR_STATUS, {6'h00, c[1:0]});
            chk(rc, c[1:0]);
            chk(mfm, mfm_t[c]);
            chk(fm, fm_t[c]);
            chk(dens, c == 0 || c == 3);
            chk({hi_out, lo_out}, c[1:0]);
            chk(pd, c == 3 ? DLY_1 : DLY_3);
        end
        for (int p = 1; p < 8; p++) begin
            u_host_model.write_reg(ADDR_STATUS, {3'h0, p[2:0], 2'h2});
            chk(wdc, p[2:0]);
            chk(pd, dly_t[p]);
        end
        u_host_model.write_reg(ADDR_STATUS, 8'h01);
        @(posedge clk_sys);
        cfg.density_polarity <= 1'b0;
        cfg.drive_rate_option_lo <= 1'b1;
        #1;
        chk(dens, 1'b1);
        chk(mfm, KBPS_500);
        @(posedge clk_sys);
        cfg.drive_rate_option_lo <= 1'b0;
        cfg.drive_rate_option_hi <= 1'b1;
        #1;
        chk(mfm, KBPS_2000);
        chk(fm, KBPS_NONE);
        $display("rates done");
    endtask : t_rates
    task t_soft;
        u_host_model.write_reg(ADDR_STATUS, 8'h41);
        chk(core_out.low_power, 1'b1);
        u_host_model.write_reg(ADDR_STATUS, 8'h81);
        chk(core_out.soft_reset, 1'b1);
        @(posedge clk_sys);
        #1;
        chk(core_out.soft_reset, 1'b0);
        chk(core_out.low_power, 1'b0);
        chk(rc, RATE_300K);
        chk(core_out.fifo_on, 1'b0);
        u_host_model.write_reg(ADDR_STATUS, 8'h41);
        u_host_model.read_reg(ADDR_STATUS, d, oe);
        chk(core_out.low_power, 1'b0);
        @(posedge clk_sys);
        cfg.config_control_rate <= RATE_1M;
        cfg.config_control_wr <= 1'b1;
        @(posedge clk_sys);
        cfg.config_control_wr <= 1'b0;
        #1;
        chk(rc, RATE_1M);
        $display("soft reset done");
    endtask : t_soft
    task t_enh;
        u_host_model.write_reg(ADDR_TAPE, 8'h03);
        u_host_model.read_reg(ADDR_TAPE, d, oe);
        chk(d & oe, 8'h03);
        @(posedge clk_sys);
        cfg.enhanced_mode_two <= 1'b1;
        cfg.drive_type_config <= 8'he4;
        cfg.boot_drive_config <= 2'h2;
        lo_in <= 1'b1;
        hi_in <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            cfg.last_drive <= i[1:0];
            repeat (4) @(posedge clk_sys);
            u_host_model.read_reg(ADDR_TAPE, d, oe);
            chk(d, {2'h1, i[1:0], 4'hb});
            chk(oe, OE_ALL);
        end
        chk(lo_oe, 1'b0);
        chk(hi_oe, 1'b0);
        cfg.enhanced_mode_two <= 1'b0;
        $display("enhanced done");
    endtask : t_enh
    task t_cmd;
        u_host_model.put_byte(8'h03, ok);
        chk(ok, 1'b1);
        chk(core_out.cmd_byte_valid, 1'b1);
        chk(core_out.cmd_byte, 8'h03);
        u_host_model.read_reg(ADDR_STATUS, d, oe);
        chk(d[ST_BUSY], 1'b1);
        $display("command done");
    endtask : t_cmd
    task t_exec;
        @(posedge clk_sys);
        cfg.polled_mode <= 1'b1;
        core_in.drive_seek_flag <= 4'h5;
        cfg.configure_fifo_en <= 1'b1;
        cfg.configure_track <= 8'h07;
        cfg.configure_wr <= 1'b1;
        core_in.go_exec <= 1'b1;
        @(posedge clk_sys);
        cfg.configure_wr <= 1'b0;
        core_in.go_exec <= 1'b0;
        #1;
        chk(core_out.write_delay_code_track, 8'h07);
        chk(core_out.fifo_on, 1'b1);
        u_host_model.put_byte(8'h5a, ok);
        u_host_model.read_reg(ADDR_STATUS, d, oe);
        chk(d, 8'hb5);
        chk(core_out.disk_data, 8'h5a);
        @(posedge clk_sys);
        core_in.disk_pop <= 1'b1;
        repeat (2) @(posedge clk_sys);
        core_in.disk_pop <= 1'b0;
        core_in.result_valid <= 1'b1;
        core_in.result_last <= 1'b1;
        core_in.result_data <= 8'hc3;
        #1;
        chk(core_out.xfer_error, 1'b1);
        chk(core_out.disk_data, PAD_BYTE);
        @(posedge clk_sys);
        u_host_model.read_reg(ADDR_STATUS, d, oe);
        chk(d, 8'hd5);
        u_host_model.read_reg(ADDR_DATA, d, oe);
        chk(d, 8'hc3);
        u_host_model.read_reg(ADDR_STATUS, d, oe);
        chk(d, 8'h85);
        $display("execution done");
    endtask : t_exec
    initial begin
        resetn = 1'b0;
        cfg = '0;
        cfg.density_polarity = 1'b1;
        core_in = '0;
        lo_in = 1'b0;
        hi_in = 1'b1;
        repeat (10) @(posedge clk_sys);
        resetn <= 1'b1;
        #1;
        t_reset();
        t_rates();
        t_soft();
        t_enh();
        t_cmd();
        t_exec();
        end_sim();
    end
endmodule : floppy_regs_test
